// file: logic/pdc_consts.svh
// Register offsets, field positions, reset values and reserved divider code of the synthesizer configuration
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH
// Register byte offsets on the control port
`define PDC_ADDR_REF_OUT 8'h3C
`define PDC_ADDR_FBDIV_A 8'h3D
`define PDC_ADDR_FBDIV_B 8'h3E
`define PDC_ADDR_OSC_BIAS 8'h3F
`define PDC_ADDR_EMPH 8'h48
`define PDC_ADDR_TRIG 8'h57
// Reset values
`define PDC_RST_REF_OUT 8'h01
`define PDC_RST_FBDIV_A 8'h00
`define PDC_RST_FBDIV_B 8'h20
`define PDC_RST_OSC_BIAS 8'h4F
`define PDC_RST_EMPH 8'h00
`define PDC_RST_TRIG 8'h00
// Field positions
`define PDC_REF_EN_BIT 0
`define PDC_DIV1_LSB 0
`define PDC_DIV2_LSB 2
`define PDC_DIV3_LSB 0
`define PDC_BIAS_LSB 0
`define PDC_EMPH_LSB 0
// Reserved divider code
`define PDC_DIV_CODE_RSVD 2'h3
`endif

// file: logic/pdc_pkg.sv
// Types shared by the synthesizer configuration block
package pdc_pkg;
   // Decoded first- or second-stage divide ratio
   typedef logic [2:0] pdc_ratio_t;
   // Register index
   typedef enum logic [2:0] {
      PDC_REG_REF = 3'h0,
      PDC_REG_DA = 3'h1,
      PDC_REG_DB = 3'h3,
      PDC_REG_BIAS = 3'h2,
      PDC_REG_EMPH = 3'h6,
      PDC_REG_TRIG = 3'h7,
      PDC_REG_NONE = 3'h5
   } pdc_reg_e;
endpackage : pdc_pkg

// file: logic/pdc_regs.sv
// Synthesizer feedback divider and reference output configuration registers
//
// Operation
// - Reference output follows enable bit and synth pin
// - Reference enable bit resets to one
// - Second divider codes 0,1,2 give 1,2,4
// - First divider codes 0,1,2 give 5,4,3
// - First divider output feeds second divider
// - Third divider ratio equals its binary value
// - Third divider resets to thirty-two
// - One pre-emphasis level drives every lane
`timescale 1ns/1ps
`include "pdc_consts.svh"

module pdc_regs
   import pdc_pkg::*;
#(
   parameter int LANES = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register write/read port
   input wire logic wr_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   // Synthesizer enable pin (asynchronous)
   input wire logic synth_enable_pin,
   // Synthesizer controls
   output logic ref_clock_output_pins,
   output logic [2:0] first_div_ratio,
   output logic [2:0] second_div_ratio,
   output logic [5:0] third_div_ratio,
   output logic [5:0] cascade_ratio,
   output logic [6:0] oscillator_bias_level,
   output logic [4*LANES-1:0] lane_pre_emphasis,
   output logic [7:0] trigger_ctrl
);

   // Parameter check: the lane fan-out serves one to eight lanes
   if (LANES < 1 || LANES > 8) begin : g_chk
      $error("LANES must be 1 to 8");
   end

   // Reference output control; bit 0 enables the output, bits 7:1 reserved
   logic [7:0] ref_r;
   // First divider code in bits 1:0, second divider code in bits 3:2
   logic [7:0] da_r;
   // Third divider ratio in bits 5:0
   logic [7:0] db_r;
   // Oscillator bias level in bits 6:0
   logic [7:0] bias_r;
   // Common lane pre-emphasis level in bits 3:0
   logic [7:0] emph_r;
   // Trigger output control, kept whole for the trigger logic downstream
   logic [7:0] trig_r;
   // Enable pin, first synchroniser stage; read by the second stage only
   logic pin_s1_r;
   // Enable pin, second synchroniser stage; the only copy logic may read
   logic pin_s2_r;

   // Address decode used by write and read paths
   function automatic pdc_reg_e dec(input logic [7:0] a);
      if (a == `PDC_ADDR_REF_OUT) dec = PDC_REG_REF;
      else if (a == `PDC_ADDR_FBDIV_A) dec = PDC_REG_DA;
      else if (a == `PDC_ADDR_FBDIV_B) dec = PDC_REG_DB;
      else if (a == `PDC_ADDR_OSC_BIAS) dec = PDC_REG_BIAS;
      else if (a == `PDC_ADDR_EMPH) dec = PDC_REG_EMPH;
      else if (a == `PDC_ADDR_TRIG) dec = PDC_REG_TRIG;
      else dec = PDC_REG_NONE;
   endfunction : dec

   // First stage code to ratio
   function automatic pdc_ratio_t ratio1(input logic [1:0] c);
      case (c)
         2'h0: ratio1 = 3'h5;
         2'h1: ratio1 = 3'h4;
         2'h2: ratio1 = 3'h3;
         default: ratio1 = 3'h5; // Reserved code holds the default
      endcase
   endfunction : ratio1

   // Second stage code to ratio
   function automatic pdc_ratio_t ratio2(input logic [1:0] c);
      case (c)
         2'h0: ratio2 = 3'h1;
         2'h1: ratio2 = 3'h2;
         2'h2: ratio2 = 3'h4;
         default: ratio2 = 3'h1; // Reserved code holds the default
      endcase
   endfunction : ratio2

   // Decoded target of this cycle's access, shared by writes and readback
   wire pdc_reg_e sel = dec(addr);

   // Per-register write strobes; an unmapped address strobes none,
   // so such a write is dropped without any effect
   wire wr_ref_w = wr_en && (sel == PDC_REG_REF);
   wire wr_da_w = wr_en && (sel == PDC_REG_DA);
   wire wr_db_w = wr_en && (sel == PDC_REG_DB);
   wire wr_bias_w = wr_en && (sel == PDC_REG_BIAS);
   wire wr_emph_w = wr_en && (sel == PDC_REG_EMPH);
   wire wr_trig_w = wr_en && (sel == PDC_REG_TRIG);

   // Next register values; all eight bits, reserved ones too, are kept as written
   wire [7:0] ref_nxt = wr_ref_w ? wdata : ref_r;
   wire [7:0] da_nxt = wr_da_w ? wdata : da_r;
   wire [7:0] db_nxt = wr_db_w ? wdata : db_r;
   wire [7:0] bias_nxt = wr_bias_w ? wdata : bias_r;
   wire [7:0] emph_nxt = wr_emph_w ? wdata : emph_r;
   wire [7:0] trig_nxt = wr_trig_w ? wdata : trig_r;

   // Field views of the stored registers
   wire ref_en_w = ref_r[`PDC_REF_EN_BIT]; // Reference output enable
   wire [1:0] div1_code_w = da_r[`PDC_DIV1_LSB +: 2]; // First divider code
   wire [1:0] div2_code_w = da_r[`PDC_DIV2_LSB +: 2]; // Second divider code
   // A third ratio of zero is unsupported; it passes through unchecked and
   // keeping it out is left to software
   wire [5:0] div3_val_w = db_r[`PDC_DIV3_LSB +: 6]; // Third divider ratio
   wire [6:0] bias_val_w = bias_r[`PDC_BIAS_LSB +: 7]; // Oscillator bias level
   wire [3:0] emph_val_w = emph_r[`PDC_EMPH_LSB +: 4]; // Common emphasis level

   // Decoded divide ratios; a reserved code falls back to the default ratio
   wire [2:0] r1_w = ratio1(div1_code_w);
   wire [2:0] r2_w = ratio2(div2_code_w);
   // The first stage feeds the second, so the overall ratio is their product;
   // the largest product is 5 x 4 = 20, well inside six bits
   wire [5:0] casc_w = 6'(r1_w * r2_w);

   // Readback of the addressed register, reserved bits included;
   // unmapped addresses read zero
   wire [7:0] rdata_nxt = (sel == PDC_REG_REF) ? ref_r :
                          (sel == PDC_REG_DA) ? da_r :
                          (sel == PDC_REG_DB) ? db_r :
                          (sel == PDC_REG_BIAS) ? bias_r :
                          (sel == PDC_REG_EMPH) ? emph_r :
                          (sel == PDC_REG_TRIG) ? trig_r : 8'h00;

   // Reference output runs only while enabled and the synchronised pin is high
   wire ref_out_nxt = ref_en_w & pin_s2_r;

   // One common emphasis level fanned out to every lane at once;
   // there is no way to give a single lane its own level
   wire [4*LANES-1:0] lanes_nxt;
   genvar gi;
   for (gi = 0; gi < LANES; gi++) begin : g_lane
      assign lanes_nxt[4*gi +: 4] = emph_val_w;
   end

   // Output values held during reset, derived from the register reset values
   // so that outputs and registers can never disagree after reset
   localparam logic [7:0] RST_DA = `PDC_RST_FBDIV_A;
   localparam logic [7:0] RST_DB = `PDC_RST_FBDIV_B;
   localparam logic [7:0] RST_BIAS = `PDC_RST_OSC_BIAS;
   localparam logic [7:0] RST_EMPH = `PDC_RST_EMPH;
   localparam logic [2:0] RST_R1 = ratio1(RST_DA[`PDC_DIV1_LSB +: 2]);
   localparam logic [2:0] RST_R2 = ratio2(RST_DA[`PDC_DIV2_LSB +: 2]);
   localparam logic [5:0] RST_R3 = RST_DB[`PDC_DIV3_LSB +: 6];
   localparam logic [5:0] RST_CASC = 6'(RST_R1 * RST_R2);
   localparam logic [6:0] RST_BIAS_VAL = RST_BIAS[`PDC_BIAS_LSB +: 7];
   localparam logic [3:0] RST_EMPH_VAL = RST_EMPH[`PDC_EMPH_LSB +: 4];

   // Two-flop synchroniser for the asynchronous enable pin; left without reset
   // so the pin level is tracked from the first clock, and only the second
   // stage feeds logic
   always_ff @(posedge clk) begin
      pin_s1_r <= synth_enable_pin;
      pin_s2_r <= pin_s1_r;
   end

   // Register storage: one short process per byte, synchronous active-low reset
   // Reference output control; the enable comes up set so the output is running, whenever the
   // synchronised pin is high, before software has had any chance to write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Enable bit set, reserved bits clear
         ref_r <= `PDC_RST_REF_OUT;
      end else begin
         // Keep or take the written byte
         ref_r <= ref_nxt;
      end
   end

   // First and second divider codes; changes reach the outputs two edges later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Both codes zero: divide by five, then by one
         da_r <= `PDC_RST_FBDIV_A;
      end else begin
         // Keep or take the written byte
         da_r <= da_nxt;
      end
   end

   // Third divider ratio
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Ratio of thirty-two
         db_r <= `PDC_RST_FBDIV_B;
      end else begin
         // Keep or take the written byte
         db_r <= db_nxt;
      end
   end

   // Oscillator bias; hardware never replaces the reset level by itself
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Reset bias level
         bias_r <= `PDC_RST_OSC_BIAS;
      end else begin
         // Keep or take the written byte
         bias_r <= bias_nxt;
      end
   end

   // Lane pre-emphasis level
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // No emphasis
         emph_r <= `PDC_RST_EMPH;
      end else begin
         // Keep or take the written byte
         emph_r <= emph_nxt;
      end
   end

   // Trigger output control
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Trigger output off
         trig_r <= `PDC_RST_TRIG;
      end else begin
         // Keep or take the written byte
         trig_r <= trig_nxt;
      end
   end

   // Readback register: the byte addressed on the previous edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Nothing to show during reset
         rdata <= 8'h00;
      end else begin
         // Follow the address every cycle
         rdata <= rdata_nxt;
      end
   end

   // Reference output pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Held off while in reset
         ref_clock_output_pins <= 1'b0;
      end else begin
         // Enable bit and synchronised pin together
         ref_clock_output_pins <= ref_out_nxt;
      end
   end

   // Divider ratio outputs; registered so the synthesizer sees clean levels,
   // at the cost of one cycle of latency after the storage register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Ratios of the reset codes
         first_div_ratio <= RST_R1;
         second_div_ratio <= RST_R2;
         third_div_ratio <= RST_R3;
         cascade_ratio <= RST_CASC;
      end else begin
         // Ratios of the stored codes
         first_div_ratio <= r1_w;
         second_div_ratio <= r2_w;
         third_div_ratio <= div3_val_w;
         cascade_ratio <= casc_w;
      end
   end

   // Oscillator bias level and trigger control outputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Reset levels
         oscillator_bias_level <= RST_BIAS_VAL;
         trigger_ctrl <= `PDC_RST_TRIG;
      end else begin
         // Stored levels
         oscillator_bias_level <= bias_val_w;
         trigger_ctrl <= trig_r;
      end
   end

   // Lane pre-emphasis outputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Reset level on every lane
         lane_pre_emphasis <= {LANES{RST_EMPH_VAL}};
      end else begin
         // Common level on every lane
         lane_pre_emphasis <= lanes_nxt;
      end
   end

endmodule : pdc_regs

// file: sim/pdc_regs_monitor.sv
// Assertion checker for the synthesizer configuration registers
`timescale 1ns/1ps
module pdc_regs_chk #(parameter int LANES = 8) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port and enable pin
   input wire logic wr_en,
   input wire logic synth_enable_pin,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   // Derived controls
   input wire logic ref_clock_output_pins,
   input wire logic [2:0] first_div_ratio,
   input wire logic [2:0] second_div_ratio,
   input wire logic [5:0] third_div_ratio,
   input wire logic [5:0] cascade_ratio,
   input wire logic [4*LANES-1:0] lane_pre_emphasis
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Write strobes of the divider registers
   wire w_a = wr_en && addr == 8'h3D;
   wire w_b = wr_en && addr == 8'h3E;
   property p_ref_pin; ref_clock_output_pins |-> $past(synth_enable_pin, 3); endproperty
   a_ref_pin: assert property (p_ref_pin) else $error("ref output without pin");
   property p_ref_off; wr_en && addr == 8'h3C && !wdata[0] |-> ##2 !ref_clock_output_pins;
   endproperty
   a_ref_off: assert property (p_ref_off) else $error("ref output not disabled");
   property p_first; w_a |-> ##2 first_div_ratio == ($past(wdata[1:0], 2) == 2'h1 ? 3'h4 :
      $past(wdata[1:0], 2) == 2'h2 ? 3'h3 : 3'h5); endproperty
   a_first: assert property (p_first) else $error("first ratio wrong");
   property p_second; w_a |-> ##2 second_div_ratio == ($past(wdata[3:2], 2) == 2'h3 ? 3'h1 :
      3'h1 << $past(wdata[3:2], 2)); endproperty
   a_second: assert property (p_second) else $error("second ratio wrong");
   property p_third; w_b |-> ##2 third_div_ratio == $past(wdata[5:0], 2); endproperty
   a_third: assert property (p_third) else $error("third ratio wrong");
   property p_casc; cascade_ratio == first_div_ratio * second_div_ratio; endproperty
   a_casc: assert property (p_casc) else $error("cascade ratio wrong");
   property p_emph; lane_pre_emphasis == {LANES{lane_pre_emphasis[3:0]}}; endproperty
   a_emph: assert property (p_emph) else $error("lane emphasis differs");
   property p_rst; $rose(rst_n) |-> third_div_ratio == 6'h20 && first_div_ratio == 3'h5;
   endproperty
   a_rst: assert property (p_rst) else $error("ratio reset value wrong");
endmodule : pdc_regs_chk
bind pdc_regs pdc_regs_chk #(.LANES(LANES)) i_pdc_regs_chk (.clk(clk), .rst_n(rst_n),
   .wr_en(wr_en), .synth_enable_pin(synth_enable_pin), .addr(addr), .wdata(wdata),
   .ref_clock_output_pins(ref_clock_output_pins), .first_div_ratio(first_div_ratio),
   .second_div_ratio(second_div_ratio), .third_div_ratio(third_div_ratio),
   .cascade_ratio(cascade_ratio), .lane_pre_emphasis(lane_pre_emphasis));

// file: sim/pdc_regs_tb.sv
// Self-checking testbench for the synthesizer configuration registers
`timescale 1ns/1ps
module testbench;
   logic clk = 0, rst_n = 0, wr_en = 0, pin = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, trig;
   logic ref_o;
   logic [2:0] r1, r2;
   logic [5:0] r3, rc;
   logic [6:0] bias;
   logic [31:0] emph;
   int num_errors = 0, cmp_count = 0, cycles = 0;
   pdc_regs #(.LANES(8)) i_pdc_regs (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .addr(addr),
      .wdata(wdata), .rdata(rdata), .synth_enable_pin(pin), .ref_clock_output_pins(ref_o),
      .first_div_ratio(r1), .second_div_ratio(r2), .third_div_ratio(r3), .cascade_ratio(rc),
      .oscillator_bias_level(bias), .lane_pre_emphasis(emph), .trigger_ctrl(trig));
   always #12.5 clk = ~clk;
   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic tick(int n); repeat (n) @(posedge clk); #1; endtask : tick
   // One write; hold keeps the strobe up for a back-to-back write that follows
   task automatic wr(logic [7:0] a, logic [7:0] d, bit hold = 1'b0);
      wr_en = 1; addr = a; wdata = d; tick(1);
      if (!hold) wr_en = 0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e); addr = a; tick(1); chk("rdata", rdata, e);
   endtask : rd
   // Reset values of every register and the third ratio
   task automatic t_reset;
      logic [7:0] ad[6] = '{8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h48, 8'h57};
      logic [7:0] rv[6] = '{8'h01, 8'h00, 8'h20, 8'h4F, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) rd(ad[i], rv[i]);
      chk("third", r3, 6'h20);
   endtask : t_reset
   // Every code of both cascaded dividers, reserved bits left at zero
   task automatic t_div;
      int e1, e2;
      for (int c = 0; c < 4; c++) begin
         e1 = (c == 1) ? 4 : (c == 2) ? 3 : 5;
         e2 = (c == 3) ? 1 : 1 << c;
         wr(8'h3D, {4'h0, 2'(c), 2'(c)});
         tick(2);
         chk("first", r1, e1);
         chk("second", r2, e2);
         chk("cascade", rc, e1 * e2);
         rd(8'h3D, {4'h0, 2'(c), 2'(c)});
      end
   endtask : t_div
   // Third divider limits, then back-to-back writes and an unmapped write
   task automatic t_misc;
      wr(8'h3E, 8'h3F);
      tick(2);
      chk("third", r3, 6'h3F);
      rd(8'h3E, 8'h3F);
      wr(8'h3E, 8'h01, 1'b1);
      wr(8'h3F, 8'h4A, 1'b1);
      wr(8'h48, 8'h05, 1'b1);
      wr(8'h57, 8'h83, 1'b1);
      wr(8'h40, 8'h77);
      tick(2);
      chk("third", r3, 6'h01);
      chk("bias", bias, 7'h4A);
      chk("emph", emph, {8{4'h5}});
      chk("trig", trig, 8'h83);
      rd(8'h40, 8'h00);
   endtask : t_misc
   // Reference output follows pin and enable bit
   task automatic t_ref;
      pin = 1; tick(4); chk("ref", ref_o, 1'b1);
      wr(8'h3C, 8'h00); tick(2); chk("ref", ref_o, 1'b0);
      wr(8'h3C, 8'h01); tick(2); chk("ref", ref_o, 1'b1);
      pin = 0; tick(4); chk("ref", ref_o, 1'b0);
   endtask : t_ref
   task automatic end_sim;
      if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   initial begin
      tick(4); rst_n = 1;
      t_reset(); t_div(); t_misc(); t_ref();
      rst_n = 0; tick(4); rst_n = 1;
      t_reset();
      end_sim();
   end
endmodule : testbench
